// ==== src/gpt_pkg.sv ====
package gpt_pkg;
	localparam int          REG_W        = 16;
	localparam int          DATA_W       = 32;
	localparam int          ADDR_W       = 8;
	localparam int          RUN_BIT      = 15;
	localparam int          IDLE_BIT     = 13;
	localparam int          GATE_BIT     = 6;
	localparam int          PRESC_LSB    = 4;
	localparam int          JOIN_BIT     = 3;
	localparam int          SYNC_BIT     = 2;
	localparam int          SRC_BIT      = 1;
	localparam logic [15:0] CTRL_RST     = 16'h0000;
	localparam logic [15:0] COUNT_RST    = 16'h0000;
	localparam logic [15:0] PERIOD_RST   = 16'hFFFF;
	localparam logic [15:0] SA_MASK      = 16'hA076;
	localparam logic [15:0] LOW_MASK     = 16'hA07A;
	localparam logic [15:0] HIGH_MASK    = 16'hA072;
	localparam logic [7:0]  ADDR_SA_CTRL = 8'h00;
	localparam logic [7:0]  ADDR_SA_CNT  = 8'h04;
	localparam logic [7:0]  ADDR_SA_PER  = 8'h08;
	localparam logic [7:0]  ADDR_STATUS  = 8'h0C;
	localparam logic [7:0]  PAIR_BASE    = 8'h10;
	localparam int          STRIDE_SHIFT = 4;
	localparam logic [3:0]  OFS_CTRL     = 4'h0;
	localparam logic [3:0]  OFS_CNT      = 4'h4;
	localparam logic [3:0]  OFS_PER      = 4'h8;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	typedef enum logic [1:0] {
		GPT_PS_1   = 2'h0,
		GPT_PS_8   = 2'h1,
		GPT_PS_64  = 2'h2,
		GPT_PS_256 = 2'h3
	} gpt_presc_t;

	function automatic logic [7:0] presc_limit(input logic [1:0] sel);
		unique case (gpt_presc_t'(sel))
			GPT_PS_1:   return 8'h00;
			GPT_PS_8:   return 8'h07;
			GPT_PS_64:  return 8'h3F;
			GPT_PS_256: return 8'hFF;
		endcase
	endfunction : presc_limit
endpackage : gpt_pkg

// ==== src/gpt_tick_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpt_tick_unit #(
	parameter bit ASYNC_OK = 1'b0
) (
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	input  wire logic       run,
	input  wire logic       idle_halt,
	input  wire logic       gate_en,
	input  wire logic [1:0] presc_sel,
	input  wire logic       sync_sel,
	input  wire logic       src_sel,
	input  wire logic       idle_mode,
	input  wire logic       sleep_mode,
	input  wire logic       pin,
	output logic            tick,
	output logic            gate_fall
);
	import gpt_pkg::*;

	typedef struct packed {
		logic       meta;
		logic       sync;
		logic       sync_d;
		logic       raw_d;
		logic       gate_d;
		logic [7:0] pre;
		logic [1:0] psel;
	} gpt_tick_st_t;

	gpt_tick_st_t r;
	gpt_tick_st_t s;
	logic         async_sel;
	logic [7:0]   pre_now;
	logic         active;
	logic         raw;

	always_comb begin
		s = r;
		s.meta = pin;
		s.sync = r.meta;
		s.sync_d = r.sync;
		s.raw_d = pin;
		s.gate_d = pin;
		tick = 1'b0;
		// sync select only matters on the external source
		async_sel = ASYNC_OK && src_sel && !sync_sel;
		// run, idle halt, sleep keeps only async alive
		active = run && !(idle_mode && idle_halt) && (!sleep_mode || async_sel);
		// pin edges, or instruction clock gated by the pin
		if (src_sel) begin
			raw = async_sel ? (pin && !r.raw_d) : (r.sync && !r.sync_d);
		end else begin
			raw = !gate_en || pin;
		end
		gate_fall = active && !src_sel && gate_en && r.gate_d && !pin;
		// a new ratio restarts the prescaler, so a stale count never overshoots it
		pre_now = (presc_sel != r.psel) ? 8'h00 : r.pre;
		s.psel = presc_sel;
		if (!run) begin
			s.pre = 8'h00;
		end else if (active && raw) begin
			if (pre_now >= presc_limit(presc_sel)) begin
				s.pre = 8'h00;
				tick = 1'b1;
			end else begin
				s.pre = pre_now + 8'h01;
			end
		end else begin
			s.pre = pre_now;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
		end else begin
			r <= s;
		end
	end

	a_presc_div: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		tick |-> (pre_now == presc_limit(presc_sel)))
		else $error("tick without full prescale count");
	a_idle_halt: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(idle_mode && idle_halt) |-> !tick)
		else $error("tick while halted in idle");
	a_gate_only: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(gate_en && !src_sel && tick) |-> pin)
		else $error("gated tick with gate low");
	a_sync_edge: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(src_sel && sync_sel && tick) |-> (r.sync && !r.sync_d))
		else $error("sync tick without synchronised edge");
	a_async_sleep: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(ASYNC_OK && sleep_mode && run && src_sel && !sync_sel && !idle_mode
			&& presc_sel == 2'h0 && pin && !r.raw_d) |-> tick)
		else $error("async edge lost in sleep");
endmodule : gpt_tick_unit
`default_nettype wire

// ==== src/gpt_axil_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpt_axil_slave (
	input  wire logic                       clk_sys,
	input  wire logic                       reset_n,
	input  wire logic [gpt_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [gpt_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [gpt_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [gpt_pkg::DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output logic                            wr_en,
	output logic [gpt_pkg::ADDR_W-1:0]      wr_addr,
	output logic [gpt_pkg::DATA_W-1:0]      wr_data,
	output logic [3:0]                      wr_strb,
	input  wire logic                       wr_err,
	input  wire logic [gpt_pkg::DATA_W-1:0] rd_data,
	input  wire logic                       rd_err
);
	import gpt_pkg::*;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              have_aw;
		logic              have_w;
		logic [ADDR_W-1:0] aw_addr;
		logic [DATA_W-1:0] w_data;
		logic [3:0]        w_strb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
	} gpt_axil_st_t;

	gpt_axil_st_t r;
	gpt_axil_st_t s;

	assign s_axi_awready = r.awready;
	assign s_axi_wready  = r.wready;
	assign s_axi_bvalid  = r.bvalid;
	assign s_axi_bresp   = r.bresp;
	assign s_axi_arready = r.arready;
	assign s_axi_rvalid  = r.rvalid;
	assign s_axi_rdata   = r.rdata;
	assign s_axi_rresp   = r.rresp;
	assign wr_addr       = r.aw_addr;
	assign wr_data       = r.w_data;
	assign wr_strb       = r.w_strb;

	always_comb begin
		s = r;
		// both halves held and no response pending: commit for one cycle
		wr_en = r.have_aw && r.have_w && !r.bvalid;
		if (s_axi_awvalid && r.awready) begin
			s.have_aw = 1'b1;
			s.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && r.wready) begin
			s.have_w = 1'b1;
			s.w_data = s_axi_wdata;
			s.w_strb = s_axi_wstrb;
		end
		if (wr_en) begin
			s.have_aw = 1'b0;
			s.have_w = 1'b0;
			s.bvalid = 1'b1;
			s.bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
		end else if (r.bvalid && s_axi_bready) begin
			s.bvalid = 1'b0;
		end
		s.awready = !s.have_aw && !s.bvalid;
		s.wready = !s.have_w && !s.bvalid;
		if (s_axi_arvalid && r.arready) begin
			s.rvalid = 1'b1;
			s.rdata = rd_data;
			s.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (r.rvalid && s_axi_rready) begin
			s.rvalid = 1'b0;
		end
		s.arready = !s.rvalid;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
		end else begin
			r <= s;
		end
	end

	a_read_latency: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(s_axi_arvalid && s_axi_arready) |=> (s_axi_rvalid && !s_axi_arready))
		else $error("read answer not one cycle after address");
	a_write_resp: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		wr_en |=> (s_axi_bvalid && !s_axi_awready && !s_axi_wready))
		else $error("write response missing after commit");
	c_axi_read: cover property (
		@(posedge clk_sys) disable iff (!reset_n)
		(s_axi_arvalid && s_axi_arready) ##1 (s_axi_rvalid && s_axi_rready));
endmodule : gpt_axil_slave
`default_nettype wire

// ==== src/gpt_timer_set.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpt_timer_set #(
	parameter int NUM_PAIRS = 4
) (
	input  wire logic                       clk_sys,
	input  wire logic                       reset_n,
	input  wire logic [gpt_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [gpt_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [gpt_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [gpt_pkg::DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       idle_mode,
	input  wire logic                       sleep_mode,
	input  wire logic                       external_clock_pin,
	input  wire logic [2*NUM_PAIRS-1:0]     pair_clock_pin,
	output logic                            standalone_event,
	output logic [2*NUM_PAIRS-1:0]          timer_event,
	output logic                            wake_request,
	output logic [1:0]                      adc_trigger,
	output logic [1:0]                      dma_trigger,
	output logic [gpt_pkg::REG_W-1:0]       capture_base_low,
	output logic [gpt_pkg::REG_W-1:0]       capture_base_high
);
	import gpt_pkg::*;

	localparam int NT = 2 * NUM_PAIRS;
	localparam logic [ADDR_W-1:0] PAIR_END = ADDR_W'(int'(PAIR_BASE) + NT * (1 << STRIDE_SHIFT));

	typedef struct packed {
		logic [15:0]          sa_ctrl;
		logic [15:0]          sa_cnt;
		logic [15:0]          sa_per;
		logic [NT-1:0][15:0]  ctrl;
		logic [NT-1:0][15:0]  cnt;
		logic [NT-1:0][15:0]  per;
		logic [NT:0]          flags;
		logic                 sa_evt;
		logic [NT-1:0]        t_evt;
		logic                 wake;
		logic [1:0]           adc;
		logic [1:0]           dma;
	} gpt_set_st_t;

	gpt_set_st_t        r;
	gpt_set_st_t        s;
	logic               wr_en;
	logic [ADDR_W-1:0]  wr_addr;
	logic [DATA_W-1:0]  wr_data;
	logic [3:0]         wr_strb;
	logic               wr_err;
	logic [DATA_W-1:0]  rd_data;
	logic               rd_err;
	logic               sa_tick;
	logic               sa_gfall;
	logic [NT-1:0]      tick;
	logic [NT-1:0]      gfall;

	// count or wrap; returns {match, next}
	function automatic logic [16:0] step16(input logic [15:0] c, input logic [15:0] p);
		return (c == p) ? {1'b1, COUNT_RST} : {1'b0, c + 16'h0001};
	endfunction : step16

	function automatic logic [32:0] step32(input logic [31:0] c, input logic [31:0] p);
		return (c == p) ? {1'b1, COUNT_RST, COUNT_RST} : {1'b0, c + 32'h0000_0001};
	endfunction : step32

	function automatic logic in_timers(input logic [ADDR_W-1:0] a);
		return (a >= PAIR_BASE) && (a < PAIR_END) && (a[3:0] <= OFS_PER) && (a[1:0] == 2'h0);
	endfunction : in_timers

	function automatic int tim_idx(input logic [ADDR_W-1:0] a);
		return int'((a - PAIR_BASE) >> STRIDE_SHIFT);
	endfunction : tim_idx

	function automatic logic map_err(input logic [ADDR_W-1:0] a);
		return !(a == ADDR_SA_CTRL || a == ADDR_SA_CNT || a == ADDR_SA_PER
			|| a == ADDR_STATUS || in_timers(a));
	endfunction : map_err

	// byte enables land on the low 16 bits only
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [DATA_W-1:0] d,
			input logic [3:0] b, input logic [15:0] mask);
		logic [15:0] v;
		v = old;
		if (b[0]) begin
			v[7:0] = d[7:0];
		end
		if (b[1]) begin
			v[15:8] = d[15:8];
		end
		return v & mask;
	endfunction : merge

	gpt_axil_slave u_bus (
		.clk_sys       (clk_sys),
		.reset_n       (reset_n),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_en         (wr_en),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.wr_err        (wr_err),
		.rd_data       (rd_data),
		.rd_err        (rd_err)
	);

	// only the standalone timer may count asynchronously
	gpt_tick_unit #(.ASYNC_OK(1'b1)) u_sa_tick (
		.clk_sys    (clk_sys),
		.reset_n    (reset_n),
		.run        (r.sa_ctrl[RUN_BIT]),
		.idle_halt  (r.sa_ctrl[IDLE_BIT]),
		.gate_en    (r.sa_ctrl[GATE_BIT]),
		.presc_sel  (r.sa_ctrl[PRESC_LSB+:2]),
		.sync_sel   (r.sa_ctrl[SYNC_BIT]),
		.src_sel    (r.sa_ctrl[SRC_BIT]),
		.idle_mode  (idle_mode),
		.sleep_mode (sleep_mode),
		.pin        (external_clock_pin),
		.tick       (sa_tick),
		.gate_fall  (sa_gfall)
	);

	for (genvar t = 0; t < NT; t++) begin : g_tick
		// pair timers always synchronise their pin
		gpt_tick_unit #(.ASYNC_OK(1'b0)) u_tick (
			.clk_sys    (clk_sys),
			.reset_n    (reset_n),
			.run        (r.ctrl[t][RUN_BIT]),
			.idle_halt  (r.ctrl[t][IDLE_BIT]),
			.gate_en    (r.ctrl[t][GATE_BIT]),
			.presc_sel  (r.ctrl[t][PRESC_LSB+:2]),
			.sync_sel   (1'b1),
			.src_sel    (r.ctrl[t][SRC_BIT]),
			.idle_mode  (idle_mode),
			.sleep_mode (sleep_mode),
			.pin        (pair_clock_pin[t]),
			.tick       (tick[t]),
			.gate_fall  (gfall[t])
		);
	end

	always_comb begin
		rd_err = map_err(s_axi_araddr);
		rd_data = '0;
		if (s_axi_araddr == ADDR_SA_CTRL) begin
			rd_data = {16'h0000, r.sa_ctrl};
		end else if (s_axi_araddr == ADDR_SA_CNT) begin
			rd_data = {16'h0000, r.sa_cnt};
		end else if (s_axi_araddr == ADDR_SA_PER) begin
			rd_data = {16'h0000, r.sa_per};
		end else if (s_axi_araddr == ADDR_STATUS) begin
			rd_data = DATA_W'(r.flags);
		end else if (in_timers(s_axi_araddr)) begin
			unique case (s_axi_araddr[3:0])
				OFS_CTRL: rd_data = {16'h0000, r.ctrl[tim_idx(s_axi_araddr)]};
				OFS_CNT:  rd_data = {16'h0000, r.cnt[tim_idx(s_axi_araddr)]};
				default:  rd_data = {16'h0000, r.per[tim_idx(s_axi_araddr)]};
			endcase
		end
	end

	always_comb begin
		logic [16:0] st16;
		logic [32:0] st32;
		logic [NT:0] clr;
		int          lo;
		int          hi;
		int          wi;
		st16 = '0;
		st32 = '0;
		clr = '0;
		lo = 0;
		hi = 0;
		wi = 0;
		s = r;
		s.sa_evt = 1'b0;
		s.t_evt = '0;
		wr_err = map_err(wr_addr);
		if (sa_tick) begin
			st16 = step16(r.sa_cnt, r.sa_per);
			s.sa_cnt = st16[15:0];
			s.sa_evt = st16[16];
		end
		if (sa_gfall) begin
			s.sa_evt = 1'b1;
		end
		for (int p = 0; p < NUM_PAIRS; p++) begin
			lo = 2 * p;
			hi = 2 * p + 1;
			// join bit lives in the low timer only
			if (r.ctrl[lo][JOIN_BIT]) begin
				// low word even, high word odd
				if (tick[lo]) begin
					st32 = step32({r.cnt[hi], r.cnt[lo]}, {r.per[hi], r.per[lo]});
					s.cnt[hi] = st32[31:16];
					s.cnt[lo] = st32[15:0];
					s.t_evt[hi] = st32[32];
				end
				if (gfall[lo]) begin
					s.t_evt[hi] = 1'b1;
				end
			end else begin
				for (int k = lo; k <= hi; k++) begin
					if (tick[k]) begin
						st16 = step16(r.cnt[k], r.per[k]);
						s.cnt[k] = st16[15:0];
						s.t_evt[k] = st16[16];
					end
					if (gfall[k]) begin
						s.t_evt[k] = 1'b1;
					end
				end
			end
		end
		// software writes override counting in the same cycle
		if (wr_en && !wr_err) begin
			if (wr_addr == ADDR_SA_CTRL) begin
				s.sa_ctrl = merge(r.sa_ctrl, wr_data, wr_strb, SA_MASK);
			end else if (wr_addr == ADDR_SA_CNT) begin
				s.sa_cnt = merge(r.sa_cnt, wr_data, wr_strb, 16'hFFFF);
			end else if (wr_addr == ADDR_SA_PER) begin
				s.sa_per = merge(r.sa_per, wr_data, wr_strb, 16'hFFFF);
			end else if (wr_addr == ADDR_STATUS) begin
				clr = (NT+1)'(merge(16'h0000, wr_data, wr_strb, 16'hFFFF));
			end else begin
				wi = tim_idx(wr_addr);
				unique case (wr_addr[3:0])
					OFS_CTRL: s.ctrl[wi] = merge(r.ctrl[wi], wr_data, wr_strb,
						wi[0] ? HIGH_MASK : LOW_MASK);
					OFS_CNT:  s.cnt[wi] = merge(r.cnt[wi], wr_data, wr_strb, 16'hFFFF);
					default:  s.per[wi] = merge(r.per[wi], wr_data, wr_strb, 16'hFFFF);
				endcase
			end
		end
		// write-one-to-clear; a new event in the same cycle wins
		s.flags = (r.flags & ~clr) | {s.t_evt, s.sa_evt};
		// async match in sleep asks for wake-up
		s.wake = s.sa_evt && sleep_mode;
		// converter triggers from the first two pairs only
		for (int p = 0; p < 2; p++) begin
			s.adc[p] = (p < NUM_PAIRS) && (r.ctrl[2*p][JOIN_BIT] ? s.t_evt[2*p+1] : s.t_evt[2*p]);
		end
		// DMA triggers from the first pair only
		s.dma = s.t_evt[1:0];
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			r.sa_ctrl <= CTRL_RST;
			r.sa_cnt <= COUNT_RST;
			r.sa_per <= PERIOD_RST;
			r.ctrl <= {NT{CTRL_RST}};
			r.cnt <= {NT{COUNT_RST}};
			r.per <= {NT{PERIOD_RST}};
			r.flags <= '0;
			r.sa_evt <= 1'b0;
			r.t_evt <= '0;
			r.wake <= 1'b0;
			r.adc <= '0;
			r.dma <= '0;
		end else begin
			r <= s;
		end
	end

	assign standalone_event = r.sa_evt;
	assign timer_event = r.t_evt;
	assign wake_request = r.wake;
	assign adc_trigger = r.adc;
	assign dma_trigger = r.dma;
	// time bases for capture and compare
	assign capture_base_low = r.cnt[0];
	assign capture_base_high = r.cnt[1];

	a_run_stop_hold: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(!r.sa_ctrl[RUN_BIT] && !wr_en) |=> $stable(r.sa_cnt))
		else $error("stopped timer changed count");
	a_period_wrap: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(sa_tick && r.sa_cnt == r.sa_per && !wr_en)
			|=> (r.sa_cnt == COUNT_RST && standalone_event && r.flags[0]))
		else $error("standalone period match did not wrap and flag");
	a_join_carry: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(r.ctrl[0][JOIN_BIT] && tick[0] && r.cnt[0] == 16'hFFFF && !wr_en
			&& {r.cnt[1], r.cnt[0]} != {r.per[1], r.per[0]})
			|=> (r.cnt[0] == COUNT_RST && r.cnt[1] == $past(r.cnt[1]) + 16'h0001))
		else $error("low word carry missed the high word");
	a_join_match: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(r.ctrl[0][JOIN_BIT] && tick[0] && !wr_en
			&& {r.cnt[1], r.cnt[0]} == {r.per[1], r.per[0]})
			|=> (timer_event[1] && !timer_event[0] && r.flags[2] && adc_trigger[0]))
		else $error("32-bit match not signalled on high timer");
	a_high_ignored: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(r.ctrl[0][JOIN_BIT] && !tick[0] && !wr_en) |=> $stable(r.cnt[1]))
		else $error("high word moved without low timer tick");
	c_sa_wrap: cover property (
		@(posedge clk_sys) disable iff (!reset_n)
		sa_tick && r.sa_cnt == r.sa_per);
	c_join_match: cover property (
		@(posedge clk_sys) disable iff (!reset_n)
		r.ctrl[0][JOIN_BIT] ##1 timer_event[1]);
	c_wake: cover property (
		@(posedge clk_sys) disable iff (!reset_n)
		sleep_mode ##1 wake_request);
endmodule : gpt_timer_set
`default_nettype wire

// ==== tb/gpt_pin_source.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpt_pin_source #(
	parameter int HALF = 3
) (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	output var logic  pin
);
	int cnt;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 0;
			pin <= 1'b0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			pin <= !pin;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule : gpt_pin_source
`default_nettype wire

// ==== tb/general_purpose_timer_set_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module general_purpose_timer_set_test;
	import gpt_pkg::*;
	logic clk_sys, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wake_request;
	logic idle_mode, sleep_mode, external_clock_pin, standalone_event;
	logic [7:0] s_axi_awaddr, s_axi_araddr, pair_clock_pin, timer_event;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] adc_trigger, dma_trigger;
	logic [15:0] capture_base_low, capture_base_high;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int failures = 0, checks_done = 0, cycles = 0;
	gpt_timer_set dut (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .idle_mode, .sleep_mode,
		.external_clock_pin, .pair_clock_pin, .standalone_event, .timer_event, .wake_request,
		.adc_trigger, .dma_trigger, .capture_base_low, .capture_base_high);
	gpt_pin_source src (.clk_sys, .reset_n, .pin(external_clock_pin));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = !clk_sys;
	end
	task automatic end_sim;
		if (failures == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failures++;
			end_sim();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %0h seen %0h", n, e, s);
		end
	endtask : chk
	// address and data may be taken on different edges
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		chk("bresp", s_axi_bresp, RESP_OKAY);
		s_axi_bready <= 1'b0;
		@(posedge clk_sys);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
		chk("rdata", s_axi_rdata, {16'h0000, e});
		chk("rresp", s_axi_rresp, r);
		s_axi_rready <= 1'b0;
		@(posedge clk_sys);
	endtask : rd
	// first event may follow a partial period, so only the next gap is judged
	task automatic gap(input int w, input int e);
		int n;
		n = 0;
		do @(posedge clk_sys); while (((w == 0) ? standalone_event : timer_event[w-1]) !== 1'b1);
		do begin
			@(posedge clk_sys);
			n++;
		end while (((w == 0) ? standalone_event : timer_event[w-1]) !== 1'b1);
		chk("event gap", n, e);
	endtask : gap
	task automatic t_regs;
		rd(ADDR_SA_CTRL, CTRL_RST, RESP_OKAY);
		rd(ADDR_SA_PER, PERIOD_RST, RESP_OKAY);
		rd(8'h03, 16'h0000, RESP_SLVERR);
		rd(8'hF0, 16'h0000, RESP_SLVERR);
		wr(ADDR_SA_CTRL, 16'hFFFF);
		rd(ADDR_SA_CTRL, 16'hA076, RESP_OKAY);
	endtask : t_regs
	task automatic t_presc;
		int div[4] = '{1, 8, 64, 256};
		// period loaded, then run with each ratio
		wr(ADDR_SA_PER, 16'h0001);
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_SA_CTRL, 16'h8000 | 16'(k << 4));
			gap(0, 2 * div[k]);
		end
	endtask : t_presc
	task automatic t_ext;
		wr(ADDR_SA_CTRL, 16'h8046);
		gap(0, 12);
		chk("wake awake", wake_request, 1'b0);
		sleep_mode <= 1'b1;
		wr(ADDR_SA_CTRL, 16'h8002);
		gap(0, 12);
		chk("wake asleep", wake_request, 1'b1);
		sleep_mode <= 1'b0;
		wr(ADDR_SA_PER, PERIOD_RST);
		wr(ADDR_SA_CTRL, 16'h8040);
		gap(0, 6);
	endtask : t_ext
	task automatic t_idle;
		wr(ADDR_SA_CTRL, 16'hA000);
		idle_mode <= 1'b1;
		wr(ADDR_SA_CNT, 16'h0000);
		repeat (20) @(posedge clk_sys);
		rd(ADDR_SA_CNT, 16'h0000, RESP_OKAY);
		idle_mode <= 1'b0;
		wr(ADDR_SA_CTRL, 16'h0000);
	endtask : t_idle
	task automatic t_join;
		wr(8'h10, 16'h0008);
		wr(8'h18, 16'h0003);
		wr(8'h28, 16'h0000);
		// high control ignored while joined, its idle halt too
		wr(8'h20, 16'hA000);
		wr(ADDR_STATUS, 16'h01FF);
		// low idle-halt clear keeps the joined pair running in Idle
		idle_mode <= 1'b1;
		wr(8'h10, 16'h8008);
		gap(2, 4);
		chk("adc trigger", adc_trigger, 2'b01);
		chk("dma trigger", dma_trigger, 2'b10);
		rd(ADDR_STATUS, 16'h0004, RESP_OKAY);
		idle_mode <= 1'b0;
		wr(8'h10, 16'h0008);
		wr(8'h14, 16'hFFFE);
		chk("base low", capture_base_low, 16'hFFFE);
		wr(8'h24, 16'h0000);
		wr(8'h10, 16'h8008);
		wr(8'h10, 16'h0008);
		rd(8'h24, 16'h0001, RESP_OKAY);
		chk("base high", capture_base_high, 16'h0001);
	endtask : t_join
	initial begin
		reset_n = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{idle_mode, sleep_mode, pair_clock_pin} = '0;
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		t_regs();
		t_presc();
		t_ext();
		t_idle();
		t_join();
		end_sim();
	end
endmodule : general_purpose_timer_set_test
`default_nettype wire
